/* File: psv_pkg.sv */
// Purpose: shared constants and carriers of the proximity sensing supervisor
// Assumes: 20 MHz system clock
// Notes:   register offsets are byte addresses on the two-wire bus
package psv_pkg;
	localparam int PSV_CLK_MHZ       = 20;
	localparam int PSV_HB_PULSE_US   = 500;
	localparam int PSV_HB_PULSE_CYC  = PSV_HB_PULSE_US * PSV_CLK_MHZ;
	localparam int PSV_MEAS_MAX_US   = 2000;
	localparam int PSV_MEAS_MAX_CYC  = PSV_MEAS_MAX_US * PSV_CLK_MHZ;
	localparam int PSV_SAMPLE_US     = 33333;
	localparam int PSV_SAMPLE_CYC    = PSV_SAMPLE_US * PSV_CLK_MHZ;
	localparam int PSV_TICK_MS       = 100;
	localparam int PSV_TICK_CYC      = PSV_TICK_MS * 1000 * PSV_CLK_MHZ;

	localparam logic [6:0] PSV_I2C_ADDR  = 7'h44;
	localparam logic [3:0] PSV_I2C_BITS  = 4'h8;

	localparam logic [7:0] PSV_OFS_CMD         = 8'h04;
	localparam logic [7:0] PSV_OFS_MOVE_RAW_H  = 8'h21;
	localparam logic [7:0] PSV_OFS_MOVE_RAW_L  = 8'h22;
	localparam logic [7:0] PSV_OFS_TEMP_REF_H  = 8'h22;
	localparam logic [7:0] PSV_OFS_TEMP_REF_L  = 8'h24;
	localparam logic [7:0] PSV_OFS_REF_HOLD_H  = 8'h25;
	localparam logic [7:0] PSV_OFS_REF_HOLD_L  = 8'h26;
	localparam logic [7:0] PSV_OFS_FILT_HOLD   = 8'h27;
	localparam logic [7:0] PSV_OFS_IN_READ     = 8'h28;
	localparam logic [7:0] PSV_OFS_RETRY       = 8'h29;
	localparam logic [7:0] PSV_OFS_CFG         = 8'h2a;
	localparam logic [7:0] PSV_OFS_STATUS      = 8'h2b;

	localparam int PSV_CMD_STANDALONE = 0;
	localparam int PSV_CMD_SENSE_OFF  = 5;
	localparam int PSV_CMD_SENSE_ON   = 6;
	localparam int PSV_CFG_HB         = 0;
	localparam int PSV_CFG_MODE_LSB   = 1;
	localparam int PSV_CFG_QR         = 3;
	localparam int PSV_CFG_HH         = 4;
	localparam int PSV_CFG_BURST_LSB  = 5;
	localparam logic [7:0] PSV_CFG_RST = 8'h00;

	localparam logic [7:0]  PSV_FILT_RELOAD    = 8'hff;
	localparam logic [7:0]  PSV_IN_READ_RELOAD = 8'h0a;
	localparam logic [7:0]  PSV_RETRY_RELOAD   = 8'h32;
	localparam logic [15:0] PSV_REF_HOLD_RELOAD = 16'h00ff;
	localparam logic [15:0] PSV_QR_SLOPE_MIN   = 16'h0010;

	typedef enum logic [1:0] {
		PSV_UI_PROX,
		PSV_UI_PROX_MOVE,
		PSV_UI_PROX_TOUCH
	} psv_ui_t;

	typedef struct packed {
		logic        prox_state;
		logic        touch_state;
		logic        cal_active;
		logic        cal_error;
		logic        conv_done;
		logic        movement_event;
		logic [15:0] prox_count;
		logic [15:0] movement_raw;
		logic [15:0] temp_ref;
	} psv_meas_t;

	typedef struct packed {
		logic conv_start;
		logic conv_chan;
		logic high_sensitivity;
		logic comp_enable;
		logic movement_enable;
		logic nomove_timeout_enable;
		logic prox_output;
		logic quick_release;
	} psv_ctl_t;
endpackage : psv_pkg

/* File: psv_i2c_slave.sv */
// Purpose: two-wire bus slave giving byte access to the supervisor registers
// Assumes: scl and sda arrive asynchronously; sampled at 20 MHz
// Notes:   first written byte sets the pointer; pointer advances per byte
`timescale 1ns/1ps
module psv_i2c_slave (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	output logic [7:0]      ptr,
	output logic            wr_en,
	output logic [7:0]      wr_addr,
	output logic [7:0]      wr_data,
	input  wire logic [7:0] rd_data
);
	import psv_pkg::*;

	typedef enum logic [2:0] {I2_IDLE, I2_ADDR, I2_ACK, I2_WR, I2_RD, I2_RACK} psv_i2c_st_t;

	psv_i2c_st_t st_reg;
	logic [2:0]  scl_sh_reg;
	logic [2:0]  sda_sh_reg;
	logic [7:0]  sh_reg;
	logic [7:0]  tx_reg;
	logic [3:0]  cnt_reg;
	logic        rw_reg;
	logic        first_reg;
	logic        oe_reg;
	logic [7:0]  ptr_reg;
	logic        wr_en_reg;
	logic [7:0]  wr_addr_reg;
	logic [7:0]  wr_data_reg;

	// index 0 is the first sync stage, read only by index 1
	wire scl_rise  = scl_sh_reg[1] & ~scl_sh_reg[2];
	wire scl_fall  = ~scl_sh_reg[1] & scl_sh_reg[2];
	wire scl_high  = scl_sh_reg[1] & scl_sh_reg[2];
	wire sda_bit   = sda_sh_reg[1];
	wire bus_start = scl_high & ~sda_sh_reg[1] & sda_sh_reg[2];
	wire bus_stop  = scl_high & sda_sh_reg[1] & ~sda_sh_reg[2];
	wire byte_full = cnt_reg == PSV_I2C_BITS;

	assign sda_out = 1'b0;
	assign sda_oe  = oe_reg;
	assign ptr     = ptr_reg;
	assign wr_en   = wr_en_reg;
	assign wr_addr = wr_addr_reg;
	assign wr_data = wr_data_reg;

	// address match does not depend on any sleep state
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= I2_IDLE;
			scl_sh_reg <= 3'h7;
			sda_sh_reg <= 3'h7;
			sh_reg <= 8'h00;
			tx_reg <= 8'h00;
			cnt_reg <= 4'h0;
			rw_reg <= 1'b0;
			first_reg <= 1'b0;
			oe_reg <= 1'b0;
			ptr_reg <= 8'h00;
			wr_en_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			wr_data_reg <= 8'h00;
		end else begin
			scl_sh_reg <= {scl_sh_reg[1:0], scl_in};
			sda_sh_reg <= {sda_sh_reg[1:0], sda_in};
			wr_en_reg <= 1'b0;
			if (bus_start) begin
				st_reg <= I2_ADDR;
				cnt_reg <= 4'h0;
				first_reg <= 1'b1;
				oe_reg <= 1'b0;
			end else if (bus_stop) begin
				st_reg <= I2_IDLE;
				oe_reg <= 1'b0;
			end else if (scl_rise) begin
				if (st_reg == I2_ADDR || st_reg == I2_WR) begin
					sh_reg <= {sh_reg[6:0], sda_bit};
					cnt_reg <= cnt_reg + 4'h1;
				end
				if (st_reg == I2_RACK && sda_bit)
					st_reg <= I2_IDLE;
			end else if (scl_fall) begin
				unique case (st_reg)
					I2_IDLE: ;
					I2_ADDR: if (byte_full) begin
						if (sh_reg[7:1] == PSV_I2C_ADDR) begin
							st_reg <= I2_ACK;
							oe_reg <= 1'b1;
							rw_reg <= sh_reg[0];
						end else
							st_reg <= I2_IDLE;
					end
					I2_WR: if (byte_full) begin
						st_reg <= I2_ACK;
						oe_reg <= 1'b1;
						first_reg <= 1'b0;
						if (first_reg)
							ptr_reg <= sh_reg;
						else begin
							wr_en_reg <= 1'b1;
							wr_addr_reg <= ptr_reg;
							wr_data_reg <= sh_reg;
							ptr_reg <= ptr_reg + 8'h01;
						end
					end
					I2_ACK, I2_RACK: if (rw_reg) begin
						st_reg <= I2_RD;
						tx_reg <= {rd_data[6:0], 1'b0};
						oe_reg <= ~rd_data[7];
						cnt_reg <= 4'h1;
					end else begin
						st_reg <= I2_WR;
						oe_reg <= 1'b0;
						cnt_reg <= 4'h0;
					end
					I2_RD: if (byte_full) begin
						st_reg <= I2_RACK;
						oe_reg <= 1'b0;
						ptr_reg <= ptr_reg + 8'h01;
					end else begin
						oe_reg <= ~tx_reg[7];
						tx_reg <= {tx_reg[6:0], 1'b0};
						cnt_reg <= cnt_reg + 4'h1;
					end
				endcase
			end
		end
	end
endmodule : psv_i2c_slave

/* File: psv_supervisor.sv */
// Purpose: runtime supervisor of a single-pin capacitive proximity controller
// Assumes: 20 MHz sys_clk; analog engine on the same clock drives meas
// Notes:   registers reached over the two-wire bus slave below
// Notes on behaviour
// - each sensing event gives one 500 us heartbeat pulse per burst when enabled
// - pulse sits in the stabilise interval, before that event's conversions
// - in burst sampling the pulse repeats before every burst
// - each measurement ends within a fixed maximum after its pulse
// - heartbeat off after reset; strap or host standalone setup enables it
// - host configures over the bus, then commands standalone output mode
// - quick release watches only the proximity channel slope
// - one qualifying release sets quick release; it clears when proximity drops
// - temperature and interference tracking frozen while proximity is active
// - three behaviours: no movement, continuous movement, proximity plus touch
// - hand-held or quick release forces movement sensing and no-movement time-out
// - sensitivity pin high selects default, low selects more sensitive
// - movement uses its own conversion slot, apart from proximity
// - proximity calibration and calibration error force proximity output on
// - bus runs up to 400 kbit/s and answers its address while sleeping
`timescale 1ns/1ps
module psv_supervisor #(
	parameter int HB_PULSE_CYC = psv_pkg::PSV_HB_PULSE_CYC,
	parameter int MEAS_MAX_CYC = psv_pkg::PSV_MEAS_MAX_CYC,
	parameter int SAMPLE_CYC   = psv_pkg::PSV_SAMPLE_CYC,
	parameter int TICK_CYC     = psv_pkg::PSV_TICK_CYC
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	output logic                   heartbeat_output_pin,
	input  wire logic              sensitivity_select_pin,
	input  wire logic              heartbeat_strap_pin,
	input  psv_pkg::psv_meas_t     meas,
	output psv_pkg::psv_ctl_t      ctl
);
	import psv_pkg::*;

	typedef enum logic [1:0] {SQ_IDLE, SQ_STAB, SQ_PROX, SQ_MOVE} psv_seq_t;

	localparam logic [7:0] T_RELOAD [3] = '{PSV_FILT_RELOAD, PSV_IN_READ_RELOAD,
		PSV_RETRY_RELOAD};

	psv_seq_t    state_reg;
	psv_seq_t    state_next;
	psv_ctl_t    ctl_reg;
	psv_ctl_t    ctl_next;
	logic        sens_s1_reg;
	logic        sens_s2_reg;
	logic        strap_s1_reg;
	logic        strap_s2_reg;
	logic        strap_done_reg;
	logic        otp_hb_reg;
	logic        standalone_reg;
	logic        sensing_reg;
	logic [7:0]  cfg_reg;
	logic [7:0]  ptr;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [7:0]  wr_data;
	logic [7:0]  rd_data_reg;
	logic [7:0]  rd_next;
	logic [23:0] period_reg;
	logic [23:0] dur_reg;
	logic [23:0] tick_reg;
	logic [2:0]  burst_reg;
	logic        hb_reg;
	logic        start_prox;
	logic        start_move;
	logic [15:0] prev_count_reg;
	logic        qr_reg;
	logic        qr_next;
	logic        cal_err_prev_reg;
	logic [7:0]  tmr_reg [3];
	logic [2:0]  t_load;
	logic [15:0] ref_hold_reg;

	psv_i2c_slave u_bus (
		.sys_clk (sys_clk),
		.rst     (rst),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.sda_out (sda_out),
		.sda_oe  (sda_oe),
		.ptr     (ptr),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.rd_data (rd_data_reg)
	);

	// configuration decode
	wire [1:0] ui_code  = cfg_reg[PSV_CFG_MODE_LSB +: 2];
	wire       ui_move  = ui_code == PSV_UI_PROX_MOVE;
	wire       ui_touch = ui_code == PSV_UI_PROX_TOUCH;
	wire       qr_en    = cfg_reg[PSV_CFG_QR];
	wire       hh_en    = cfg_reg[PSV_CFG_HH];
	wire       cmd_wr   = wr_en && wr_addr == PSV_OFS_CMD;
	wire       cfg_wr   = wr_en && wr_addr == PSV_OFS_CFG;
	wire       hb_active = otp_hb_reg | (standalone_reg & cfg_reg[PSV_CFG_HB]);

	wire prox_out = meas.prox_state | meas.touch_state | meas.cal_active
		| meas.cal_error;
	wire move_en  = ui_move | (ui_touch & meas.prox_state & ~meas.touch_state)
		| qr_en | hh_en;

	// sequencer timing
	wire period_done = period_reg == 24'h0;
	wire tick        = tick_reg == 24'h0;
	wire dur_zero    = dur_reg == 24'h0;
	wire conv_end    = meas.conv_done | dur_zero;
	wire burst_more  = burst_reg != 3'h0;
	wire enter_stab  = state_next == SQ_STAB && (state_reg != SQ_STAB || dur_zero);

	always_comb begin
		state_next = state_reg;
		start_prox = 1'b0;
		start_move = 1'b0;
		unique case (state_reg)
			SQ_IDLE: if (period_done && sensing_reg)
				state_next = SQ_STAB;
			SQ_STAB: if (dur_zero) begin
				state_next = SQ_PROX;
				start_prox = 1'b1;
			end
			SQ_PROX: if (conv_end) begin
				if (move_en) begin
					state_next = SQ_MOVE;
					start_move = 1'b1;
				end else
					state_next = burst_more ? SQ_STAB : SQ_IDLE;
			end
			SQ_MOVE: if (conv_end)
				state_next = burst_more ? SQ_STAB : SQ_IDLE;
		endcase
	end

	// quick release: falling proximity count at a proximity conversion end
	wire prox_sample = state_reg == SQ_PROX && meas.conv_done;
	wire slope_rel   = prev_count_reg > meas.prox_count
		&& (prev_count_reg - meas.prox_count) >= PSV_QR_SLOPE_MIN;
	assign qr_next = meas.prox_state & (qr_reg | (qr_en & prox_sample & slope_rel
		& (meas.prox_state | meas.touch_state)));

	assign ctl_next.conv_start            = start_prox | start_move;
	assign ctl_next.conv_chan             = start_move;
	assign ctl_next.high_sensitivity      = ~sens_s2_reg;
	assign ctl_next.comp_enable           = ~prox_out;
	assign ctl_next.movement_enable       = move_en;
	assign ctl_next.nomove_timeout_enable = qr_en | hh_en;
	assign ctl_next.prox_output           = prox_out;
	assign ctl_next.quick_release         = qr_next;

	// readback selection
	assign rd_next =
		ptr == PSV_OFS_MOVE_RAW_H ? meas.movement_raw[15:8] :
		ptr == PSV_OFS_MOVE_RAW_L ? meas.movement_raw[7:0] :
		ptr == PSV_OFS_TEMP_REF_L ? meas.temp_ref[7:0] :
		ptr == PSV_OFS_REF_HOLD_H ? ref_hold_reg[15:8] :
		ptr == PSV_OFS_REF_HOLD_L ? ref_hold_reg[7:0] :
		ptr == PSV_OFS_FILT_HOLD  ? tmr_reg[0] :
		ptr == PSV_OFS_IN_READ    ? tmr_reg[1] :
		ptr == PSV_OFS_RETRY      ? tmr_reg[2] :
		ptr == PSV_OFS_CFG        ? cfg_reg :
		ptr == PSV_OFS_STATUS     ? {3'h0, sensing_reg, standalone_reg, hb_active,
		                             ctl_reg.quick_release, ctl_reg.prox_output} :
		8'h00;

	assign heartbeat_output_pin = hb_reg;
	assign ctl = ctl_reg;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sens_s1_reg <= 1'b1;
			sens_s2_reg <= 1'b1;
			strap_s1_reg <= 1'b0;
			strap_s2_reg <= 1'b0;
			strap_done_reg <= 1'b0;
			otp_hb_reg <= 1'b0;
			standalone_reg <= 1'b0;
			sensing_reg <= 1'b1;
			cfg_reg <= PSV_CFG_RST;
			rd_data_reg <= 8'h00;
			ctl_reg <= '0;
		end else begin
			sens_s1_reg <= sensitivity_select_pin;
			sens_s2_reg <= sens_s1_reg;
			strap_s1_reg <= heartbeat_strap_pin;
			strap_s2_reg <= strap_s1_reg;
			strap_done_reg <= 1'b1;
			if (strap_done_reg && !otp_hb_reg)
				otp_hb_reg <= strap_s2_reg;
			if (cmd_wr && wr_data[PSV_CMD_STANDALONE])
				standalone_reg <= 1'b1;
			if (cmd_wr && wr_data[PSV_CMD_SENSE_OFF])
				sensing_reg <= 1'b0;
			else if (cmd_wr && wr_data[PSV_CMD_SENSE_ON])
				sensing_reg <= 1'b1;
			if (cfg_wr)
				cfg_reg <= wr_data;
			rd_data_reg <= rd_next;
			ctl_reg <= ctl_next;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= SQ_IDLE;
			period_reg <= 24'h0;
			dur_reg <= 24'h0;
			tick_reg <= 24'h0;
			burst_reg <= 3'h0;
			hb_reg <= 1'b0;
			prev_count_reg <= 16'h0;
			qr_reg <= 1'b0;
			cal_err_prev_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			period_reg <= period_done ? 24'(SAMPLE_CYC - 1) : period_reg - 24'h1;
			tick_reg <= tick ? 24'(TICK_CYC - 1) : tick_reg - 24'h1;
			if (enter_stab)
				dur_reg <= 24'(HB_PULSE_CYC - 1);
			else if (start_prox || start_move)
				dur_reg <= 24'(MEAS_MAX_CYC - 1);
			else if (!dur_zero)
				dur_reg <= dur_reg - 24'h1;
			if (state_reg == SQ_IDLE && enter_stab)
				burst_reg <= cfg_reg[PSV_CFG_BURST_LSB +: 3];
			else if (state_reg != SQ_IDLE && enter_stab)
				burst_reg <= burst_reg - 3'h1;
			hb_reg <= hb_active && state_next == SQ_STAB
				&& (enter_stab || hb_reg);
			if (prox_sample)
				prev_count_reg <= meas.prox_count;
			qr_reg <= qr_next;
			cal_err_prev_reg <= meas.cal_error;
		end
	end

	// countdown timers: filter hold, input read, calibration retry
	assign t_load[0] = prox_out & ~ctl_reg.prox_output;
	assign t_load[1] = tick & tmr_reg[1] == 8'h00;
	assign t_load[2] = meas.cal_error & ~cal_err_prev_reg;

	for (genvar gi = 0; gi < 3; gi++) begin : g_tmr
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst)
				tmr_reg[gi] <= 8'h00;
			else if (t_load[gi])
				tmr_reg[gi] <= T_RELOAD[gi];
			else if (tick && tmr_reg[gi] != 8'h00)
				tmr_reg[gi] <= tmr_reg[gi] - 8'h01;
		end
	end

	// reference hold timer restarts on movement
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			ref_hold_reg <= 16'h0;
		else if (meas.movement_event)
			ref_hold_reg <= PSV_REF_HOLD_RELOAD;
		else if (tick && ref_hold_reg != 16'h0)
			ref_hold_reg <= ref_hold_reg - 16'h1;
	end

	// checking helpers
	logic [23:0] hb_len_reg;
	logic [23:0] busy_len_reg;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hb_len_reg <= 24'h0;
			busy_len_reg <= 24'h0;
		end else begin
			hb_len_reg <= hb_reg ? hb_len_reg + 24'h1 : 24'h0;
			busy_len_reg <= (start_prox || start_move || state_next == SQ_STAB
				|| state_next == SQ_IDLE) ? 24'h0 : busy_len_reg + 24'h1;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_hb_width;
		$fell(hb_reg) && $past(hb_active) |-> hb_len_reg == 24'(HB_PULSE_CYC);
	endproperty
	a_hb_width: assert property (p_hb_width) else $error("heartbeat width wrong");

	property p_hb_before_conv;
		start_prox && hb_reg |=> !hb_reg && ctl.conv_start;
	endproperty
	a_hb_before_conv: assert property (p_hb_before_conv) else $error("conv before pulse");

	property p_burst_repeat;
		(state_reg == SQ_PROX || state_reg == SQ_MOVE) && state_next == SQ_STAB
			&& hb_active |=> hb_reg;
	endproperty
	a_burst_repeat: assert property (p_burst_repeat) else $error("burst lacks pulse");

	property p_meas_bound;
		busy_len_reg < 24'(MEAS_MAX_CYC);
	endproperty
	a_meas_bound: assert property (p_meas_bound) else $error("measurement too long");

	property p_hb_off;
		!otp_hb_reg && !standalone_reg |-> !hb_active ##1 !heartbeat_output_pin;
	endproperty
	a_hb_off: assert property (p_hb_off) else $error("heartbeat not disabled");

	property p_qr_clear;
		!meas.prox_state |=> !ctl.quick_release;
	endproperty
	a_qr_clear: assert property (p_qr_clear) else $error("quick release held");

	property p_comp_freeze;
		meas.prox_state || meas.touch_state |=> !ctl.comp_enable;
	endproperty
	a_comp_freeze: assert property (p_comp_freeze) else $error("tracking not frozen");

	property p_move_forced;
		cfg_reg[PSV_CFG_QR] |=> ctl.movement_enable && ctl.nomove_timeout_enable;
	endproperty
	a_move_forced: assert property (p_move_forced) else $error("movement not forced");

	property p_sens_low;
		!sensitivity_select_pin [*3] |=> ctl.high_sensitivity;
	endproperty
	a_sens_low: assert property (p_sens_low) else $error("sensitivity not raised");

	property p_cal_force;
		meas.cal_active || meas.cal_error |=> ctl.prox_output;
	endproperty
	a_cal_force: assert property (p_cal_force) else $error("calibration output off");

	property p_hb_idle;
		state_reg != SQ_STAB |-> !heartbeat_output_pin;
	endproperty
	a_hb_idle: assert property (p_hb_idle) else $error("heartbeat outside stabilise");

	c_burst: cover property (state_reg == SQ_MOVE && state_next == SQ_STAB && hb_active);
	c_qr: cover property ($rose(ctl.quick_release));
	c_standalone: cover property ($rose(standalone_reg));
	c_cal: cover property (meas.cal_error ##1 ctl.prox_output);
endmodule : psv_supervisor

/* File: psv_host_model.sv */
// Purpose: two-wire bus master standing in for the host controller
// Assumes: sda resolved outside with a pull-up; scl driven only here
// Notes:   phases of 13 sys_clk give about 385 kbit/s
`timescale 1ns/1ps
module psv_host_model (
	input  wire logic sys_clk,
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda
);
	localparam int Q = 13;

	initial begin
		scl      = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic q;
		repeat (Q) @(negedge sys_clk);
	endtask : q

	// data only moves while scl is low
	task automatic bit_io(input logic b, output logic r);
		sda_pull = !b;
		q();
		scl = 1'b1;
		q();
		r = sda;
		q();
		scl = 1'b0;
		q();
	endtask : bit_io

	task automatic start;
		sda_pull = 1'b0;
		q();
		scl = 1'b1;
		q();
		sda_pull = 1'b1;
		q();
		scl = 1'b0;
		q();
	endtask : start

	task automatic stop;
		sda_pull = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda_pull = 1'b0;
		q();
	endtask : stop

	// ninth bit: 1 releases for the device, 0 acks a read byte
	task automatic byte_io(input logic [7:0] d, input logic nine, output logic [7:0] r,
		output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
		bit_io(nine, a);
		ack = !a;
	endtask : byte_io

	task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
		output logic ok);
		logic [7:0] r;
		logic       k1, k2, k3;
		start();
		byte_io({dev, 1'b0}, 1'b1, r, k1);
		byte_io(a, 1'b1, r, k2);
		byte_io(d, 1'b1, r, k3);
		stop();
		ok = k1 & k2 & k3;
	endtask : write_reg

	// polling answer tells the host the device is alive
	task automatic read_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		logic [7:0] r;
		logic       k1, k2, k3, k4;
		start();
		byte_io({dev, 1'b0}, 1'b1, r, k1);
		byte_io(a, 1'b1, r, k2);
		start();
		byte_io({dev, 1'b1}, 1'b1, r, k3);
		byte_io(8'hff, 1'b1, d, k4);
		stop();
		ok = k1 & k2 & k3;
	endtask : read_reg
endmodule : psv_host_model

/* File: psv_supervisor_tb.sv */
// Purpose: self-checking bench of the proximity sensing supervisor
// Assumes: short sim counts; bench plays the analog engine on meas
// Notes:   random values from a fixed seed
`timescale 1ns/1ps
module psv_supervisor_tb;
	import psv_pkg::*;
	localparam int HB  = 20;
	localparam int SMP = 200;
	logic        sys_clk, rst, scl, host_pull, sens_pin, strap, sda_out, sda_oe, hb_pin, ok;
	wire         sda_line;
	psv_meas_t   meas;
	psv_ctl_t    ctl;
	logic [15:0] prox_val, junk_val;
	logic        conv_is_move;
	int          num_errors, tests_run, conv_left, conv_delay, n, r;

	assign sda_line = !(host_pull | (sda_oe & !sda_out));

	psv_supervisor #(.HB_PULSE_CYC(HB), .MEAS_MAX_CYC(40), .SAMPLE_CYC(SMP), .TICK_CYC(50))
	u_psv_supervisor (.sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .heartbeat_output_pin(hb_pin),
		.sensitivity_select_pin(sens_pin), .heartbeat_strap_pin(strap), .meas(meas), .ctl(ctl));
	psv_host_model u_psv_host_model (.sys_clk(sys_clk), .scl(scl), .sda_pull(host_pull),
		.sda(sda_line));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// analog engine: answers each conversion after conv_delay cycles
	always @(negedge sys_clk) begin
		meas.conv_done = 1'b0;
		if (ctl.conv_start === 1'b1) begin
			conv_left    = conv_delay;
			conv_is_move = ctl.conv_chan;
		end else if (conv_left > 0) begin
			conv_left = conv_left - 1;
			if (conv_left == 0) begin
				meas.conv_done  = 1'b1;
				meas.prox_count = conv_is_move ? junk_val : prox_val;
			end
		end
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask : cyc

	task automatic wait_hb(input logic lvl, input int lim);
		for (int i = 0; i < lim && hb_pin !== lvl; i++) cyc(1);
		if (hb_pin !== lvl) begin
			chk("heartbeat wait", 16'(lvl), 16'(hb_pin));
			close_out();
		end
	endtask : wait_hb

	task automatic rises(input int k, output int cnt);
		logic p;
		cnt = 0;
		p   = hb_pin;
		repeat (k) begin
			cyc(1);
			if (hb_pin === 1'b1 && p !== 1'b1) cnt++;
			p = hb_pin;
		end
	endtask : rises

	// quiet gap longer than any burst spacing marks an event boundary
	task automatic wait_gap;
		int lows;
		lows = 0;
		for (int i = 0; i < 3 * SMP && lows < 60; i++) begin
			cyc(1);
			lows = (hb_pin === 1'b0) ? lows + 1 : 0;
		end
		wait_hb(1'b1, SMP);
	endtask : wait_gap

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_psv_host_model.write_reg(PSV_I2C_ADDR, a, d, ok);
		chk("write ack", 16'h1, 16'(ok));
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_psv_host_model.read_reg(PSV_I2C_ADDR, a, d, ok);
		chk($sformatf("ack of %h", a), 16'h1, 16'(ok));
		chk($sformatf("reg %h", a), 16'(exp), 16'(d));
	endtask : rd

	function automatic logic move_exp(input logic [1:0] md, input logic p, input logic t,
		input logic hh);
		return md == 2'd1 || (md == 2'd2 && p && !t) || hh;
	endfunction : move_exp

	initial begin
		cyc(90000);
		chk("watchdog", 16'h0, 16'h1);
		close_out();
	end

	initial begin
		void'($urandom(32'h73fcc092));
		rst = 1'b1;
		sens_pin = 1'b1;
		strap = 1'b0;
		meas = '0;
		prox_val = 16'h0100;
		junk_val = 16'h0000;
		conv_delay = 5;
		conv_left = 0;
		num_errors = 0;
		tests_run = 0;
		cyc(12);
		chk("ctl in reset", 16'h0, 16'(ctl));
		rst = 1'b0;
		rises(3 * SMP, n);
		chk("heartbeat after reset", 16'h0, 16'(n));
		$display("test reset done");

		meas.movement_raw = 16'($urandom);
		meas.temp_ref = 16'($urandom);
		rd(PSV_OFS_MOVE_RAW_H, meas.movement_raw[15:8]);
		rd(PSV_OFS_MOVE_RAW_L, meas.movement_raw[7:0]);
		rd(PSV_OFS_TEMP_REF_L, meas.temp_ref[7:0]);
		rd(PSV_OFS_CFG, PSV_CFG_RST);
		rd(8'h30, 8'h00);
		rd(PSV_OFS_REF_HOLD_L, 8'h00);
		rd(PSV_OFS_FILT_HOLD, 8'h00);
		rd(PSV_OFS_RETRY, 8'h00);
		u_psv_host_model.write_reg(PSV_I2C_ADDR, PSV_OFS_MOVE_RAW_H, 8'h5a, ok);
		rd(PSV_OFS_MOVE_RAW_H, meas.movement_raw[15:8]);
		u_psv_host_model.read_reg(7'h45, PSV_OFS_CFG, junk_val[7:0], ok);
		chk("foreign address ack", 16'h0, 16'(ok));
		junk_val = 16'h0000;
		$display("test registers done");

		wr(PSV_OFS_CFG, 8'h01);
		rises(2 * SMP, n);
		chk("heartbeat before standalone", 16'h0, 16'(n));
		wr(PSV_OFS_CMD, 8'h01);
		wait_hb(1'b0, SMP);
		wait_hb(1'b1, 2 * SMP);
		for (n = 0; n < 100 && hb_pin === 1'b1; n++) cyc(1);
		chk("pulse width", 16'(HB), 16'(n));
		chk("conversion after pulse", 16'h1, 16'(ctl.conv_start));
		chk("first channel", 16'h0, 16'(ctl.conv_chan));
		$display("test heartbeat done");

		for (int b = 0; b <= 2; b += 2) begin
			wr(PSV_OFS_CFG, {b[2:0], 5'h01});
			wait_gap();
			rises(110, r);
			chk("pulses per event", 16'(b + 1), 16'(r + 1));
		end
		conv_delay = 1000;
		wr(PSV_OFS_CFG, 8'h21);
		wait_gap();
		wait_hb(1'b0, SMP);
		for (n = 0; n < SMP && hb_pin !== 1'b1; n++) cyc(1);
		chk("stalled conversion bound", 16'h1, 16'(n >= 40 && n <= 43));
		conv_delay = 5;
		$display("test bursts done");

		for (int m = 0; m < 4; m++) begin
			logic [1:0] md;
			md = (m == 3) ? 2'd0 : 2'(m);
			wr(PSV_OFS_CFG, {3'h0, m == 3, 1'b0, md, 1'b1});
			for (int pt = 0; pt < 4; pt++) begin
				meas.prox_state = pt[0];
				meas.touch_state = pt[1];
				cyc(4);
				chk("movement enable", 16'(move_exp(md, pt[0], pt[1], m == 3)),
					16'(ctl.movement_enable));
				if (m == 3) chk("no-move timeout", 16'h1, 16'(ctl.nomove_timeout_enable));
				if (pt != 2) chk("compensation", 16'(pt == 0), 16'(ctl.comp_enable));
			end
		end
		$display("test behaviours done");

		repeat (16) begin
			{meas.prox_state, meas.touch_state, meas.cal_active, meas.cal_error} = 4'($urandom);
			sens_pin = 1'($urandom);
			cyc(5);
			chk("proximity output", 16'(meas.prox_state | meas.touch_state | meas.cal_active |
				meas.cal_error), 16'(ctl.prox_output));
			chk("sensitivity", 16'(!sens_pin), 16'(ctl.high_sensitivity));
		end
		{meas.prox_state, meas.touch_state, meas.cal_active, meas.cal_error} = 4'h0;
		$display("test outputs done");

		wr(PSV_OFS_CFG, 8'h09);
		prox_val = 16'h0200;
		meas.prox_state = 1'b1;
		cyc(2 * SMP);
		chk("release on movement slot", 16'h0, 16'(ctl.quick_release));
		chk("release forces movement", 16'h1, 16'(ctl.movement_enable));
		prox_val = 16'h01f1;
		cyc(2 * SMP);
		chk("release below slope", 16'h0, 16'(ctl.quick_release));
		prox_val = 16'h01e1;
		cyc(2 * SMP);
		chk("release at slope", 16'h1, 16'(ctl.quick_release));
		meas.prox_state = 1'b0;
		cyc(3);
		chk("release cleared", 16'h0, 16'(ctl.quick_release));
		$display("test quick release done");

		strap = 1'b1;
		rst = 1'b1;
		cyc(3);
		chk("heartbeat in reset", 16'h0, 16'(hb_pin));
		rst = 1'b0;
		rd(PSV_OFS_CFG, PSV_CFG_RST);
		rd(PSV_OFS_STATUS, 8'h14);
		wait_hb(1'b1, 2 * SMP);
		chk("strap heartbeat", 16'h1, 16'(hb_pin));
		$display("test second reset done");
		close_out();
	end
endmodule : psv_supervisor_tb
